/* spp_regs.svh */
`ifndef SPP_REGS_SVH
`define SPP_REGS_SVH

// Register byte addresses
`define SPP_ADDR_JOB 5'h00
`define SPP_ADDR_CFG 5'h04
`define SPP_ADDR_STAT 5'h08
`define SPP_ADDR_IRQ_STAT 5'h0c
`define SPP_ADDR_IRQ_CLR 5'h10
`define SPP_ADDR_IRQ_EN 5'h14

// Job word fields
`define SPP_JOB_MODE 1:0
`define SPP_JOB_REF 2
`define SPP_JOB_VEL 15:4
`define SPP_JOB_LEN 31:16

// Job modes
`define SPP_MODE_STOP 2'h0
`define SPP_MODE_FWD 2'h1
`define SPP_MODE_BWD 2'h2
`define SPP_MODE_NEUTRAL 2'h3

// Configuration word fields
`define SPP_CFG_START 11:0
`define SPP_CFG_ACCEL 23:12
`define SPP_CFG_REFSW 24

// Status word fields
`define SPP_ST_REMAIN 15:0
`define SPP_ST_CONFIGURED 16
`define SPP_ST_PULSING 17
`define SPP_ST_ABORTED 18
`define SPP_ST_DIR 19
`define SPP_ST_DRIVE 20
`define SPP_ST_REFERENCED 21
`define SPP_ST_STOPPING 22

// Event bits of the interrupt registers
`define SPP_EV_DONE 0
`define SPP_EV_ABORT 1
`define SPP_EV_REF 2
`define SPP_EV_REJECT 3

// Reset values
`define SPP_CFG_START_RST 12'h010
`define SPP_CFG_ACCEL_RST 12'h001
`define SPP_CFG_REFSW_RST 1'b0
`define SPP_IRQ_EN_RST 4'h0

// Timing
`define SPP_CLK_MHZ 40
`define SPP_DIR_SETUP_NS 1000
`define SPP_DIR_SETUP_CYC ((`SPP_DIR_SETUP_NS * `SPP_CLK_MHZ + 999) / 1000)
`define SPP_RAMP_TICK_NS 10000
`define SPP_RAMP_TICK_CYC ((`SPP_RAMP_TICK_NS * `SPP_CLK_MHZ) / 1000)

`endif

/* spp_pkg.sv */
package spp_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ACCEL,
    ST_CRUISE,
    ST_DECEL
  } spp_state_e;

  typedef logic [11:0] spp_rate_t;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    spp_state_e st;
    spp_rate_t cfg_start;
    spp_rate_t cfg_accel;
    logic cfg_refsw;
    logic configured;
    spp_rate_t vel;
    spp_rate_t rate;
    logic [15:0] remaining;
    logic [15:0] acc_steps;
    logic [11:0] tick;
    logic [7:0] setup;
    logic dir;
    logic drv_en;
    logic step_en;
    logic aborted;
    logic stopping;
    logic ref_job;
    logic referenced;
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
    logic irq;
  } spp_top_s;

  typedef struct packed {
    logic [15:0] acc;
    logic step;
  } spp_nco_s;

  typedef struct packed {
    logic prev;
  } spp_edge_s;

endpackage

/* spp_step_if.sv */
`timescale 1ns/1ps
interface spp_step_if;
  logic [11:0] rate;
  logic en;
  logic step;
  modport gen (input rate, input en, output step);
  modport ctl (output rate, output en, input step);
endinterface

/* spp_nco.sv */
`timescale 1ns/1ps
module spp_nco (
  input wire logic ref_clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  spp_step_if.gen sif // Rate in, step pulse out
);
  import spp_pkg::*;

  spp_nco_s s;
  spp_nco_s n;
  logic [16:0] sum;

  // Phase accumulator: step rate is rate/65536 of the clock
  always_comb
  begin
    n = s;
    sum = {1'b0, s.acc} + {5'h00, sif.rate};
    n.step = 1'b0;
    if (sif.en)
    begin
      n.acc = sum[15:0];
      n.step = sum[16];
    end
    else
    begin
      n.acc = 16'h0000;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= n;
  end

  assign sif.step = s.step;
endmodule // spp_nco

/* spp_edge.sv */
`timescale 1ns/1ps
module spp_edge (
  input wire logic ref_clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic level, // Sampled level
  output logic rise // High for the cycle the level first reads high
);
  import spp_pkg::*;

  spp_edge_s s;
  spp_edge_s n;

  always_comb
  begin
    n.prev = level;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= n;
  end

  assign rise = level & ~s.prev;
endmodule // spp_edge

/* spp_top.sv */
// Notes on behaviour
// - Emit exactly as many step pulses as the commanded path length.
// - Step pulse rate follows the commanded velocity.
// - Rate profile: acceleration ramp, constant section, mirrored deceleration.
// - Passing a range limit switch halts the pulse output.
// - External stop brings motion to rest along a deceleration ramp.
// - Pulse inhibit stops step pulses at once, with no ramp.
// - Reference approach works with or without a reference switch.
// - Remaining distance and status bits are reported to the host.
// - A job carries velocity, direction and path length; it is executed.
// - Indicators show configured, pulsing and aborted.
// - Four modes: stop, start forwards, start backwards, neutral.
`timescale 1ns/1ps
`include "spp_regs.svh"
module spp_top (
  input wire logic ref_clk, // 40 MHz clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Write byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall while high
  input wire logic limit_fwd, // Forward range limit reached
  input wire logic limit_bwd, // Backward range limit reached
  input wire logic ext_stop, // External controlled stop
  input wire logic pulse_inhibit_input, // Emergency pulse inhibit
  input wire logic ref_switch, // Reference point switch
  output logic step_pulse, // Step pulse to power section
  output logic step_dir, // Direction, high for forwards
  output logic drive_enable, // Power section enabled
  output logic configured_indicator, // Configuration received
  output logic pulsing_indicator, // Pulses being output
  output logic aborted_indicator, // Positioning interrupted
  output logic irq // Level interrupt
);
  import spp_pkg::*;

  localparam logic [7:0] DIR_SETUP = 8'(`SPP_DIR_SETUP_CYC);
  localparam logic [11:0] RAMP_TICK = 12'(`SPP_RAMP_TICK_CYC);

  spp_top_s s;
  spp_top_s n;
  spp_step_if sif ();
  logic ref_rise;

  spp_nco u_nco (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .sif(sif)
  );

  spp_edge u_ref_edge (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .level(ref_switch),
    .rise(ref_rise)
  );

  function automatic logic [31:0] lanes(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction

  always_comb
  begin
    logic [3:0] ev;
    logic [3:0] clr;
    logic [31:0] wd;
    logic [31:0] stat;
    logic take_wr;
    logic moving;
    logic ramp;
    logic halt;
    logic finish;
    logic [12:0] up;
    logic [12:0] down;
    ev = 4'h0;
    clr = 4'h0;
    wd = 32'h0000_0000;
    take_wr = avs_write & ~s.waitreq;
    moving = (s.st != ST_IDLE);
    ramp = 1'b0;
    halt = 1'b0;
    finish = 1'b0;
    up = 13'h0000;
    down = 13'h0000;
    n = s;

    // Status word seen by the host
    stat = 32'h0000_0000;
    stat[`SPP_ST_REMAIN] = s.remaining;
    stat[`SPP_ST_CONFIGURED] = s.configured;
    stat[`SPP_ST_PULSING] = s.step_en;
    stat[`SPP_ST_ABORTED] = s.aborted;
    stat[`SPP_ST_DIR] = s.dir;
    stat[`SPP_ST_DRIVE] = s.drv_en;
    stat[`SPP_ST_REFERENCED] = s.referenced;
    stat[`SPP_ST_STOPPING] = s.stopping;

    // One wait cycle, then the request is taken
    n.waitreq = ~((avs_read | avs_write) & s.waitreq);
    if (avs_read & s.waitreq)
    begin
      case (avs_address)
        `SPP_ADDR_STAT: n.rdata = stat;
        `SPP_ADDR_CFG: n.rdata = {7'h00, s.cfg_refsw, s.cfg_accel,
                                  s.cfg_start};
        `SPP_ADDR_IRQ_STAT: n.rdata = {28'h0000000, s.irq_stat};
        `SPP_ADDR_IRQ_EN: n.rdata = {28'h0000000, s.irq_en};
        default: n.rdata = 32'h0000_0000;
      endcase
    end

    if (take_wr)
    begin
      case (avs_address)
        `SPP_ADDR_CFG:
        begin
          wd = lanes({7'h00, s.cfg_refsw, s.cfg_accel, s.cfg_start},
                     avs_writedata, avs_byteenable);
          // Motor data may not change under a moving axis
          if (!moving)
          begin
            n.cfg_start = wd[`SPP_CFG_START];
            n.cfg_accel = wd[`SPP_CFG_ACCEL];
            n.cfg_refsw = wd[`SPP_CFG_REFSW];
            n.configured = 1'b1;
          end
        end
        `SPP_ADDR_IRQ_CLR:
          clr = avs_writedata[3:0] & {4{avs_byteenable[0]}};
        `SPP_ADDR_IRQ_EN:
        begin
          if (avs_byteenable[0])
            n.irq_en = avs_writedata[3:0];
        end
        `SPP_ADDR_JOB:
        begin
          // Whole job arrives as one four-byte message
          wd = lanes(32'h0000_0000, avs_writedata, avs_byteenable);
          case (wd[`SPP_JOB_MODE])
            `SPP_MODE_STOP:
            begin
              if (moving)
                n.stopping = 1'b1;
            end
            `SPP_MODE_NEUTRAL:
            begin
              if (!moving)
                n.drv_en = 1'b0;
              else
                ev[`SPP_EV_REJECT] = 1'b1;
            end
            default:
            begin
              // Forwards or backwards start
              if (moving || !s.configured || ext_stop ||
                  pulse_inhibit_input ||
                  (wd[`SPP_JOB_MODE] == `SPP_MODE_FWD && limit_fwd) ||
                  (wd[`SPP_JOB_MODE] == `SPP_MODE_BWD && limit_bwd))
              begin
                ev[`SPP_EV_REJECT] = 1'b1;
              end
              else if (wd[`SPP_JOB_REF] && !s.cfg_refsw)
              begin
                // No switch fitted: the present position becomes reference
                n.referenced = 1'b1;
                ev[`SPP_EV_REF] = 1'b1;
              end
              else
              begin
                n.dir = (wd[`SPP_JOB_MODE] == `SPP_MODE_FWD);
                n.drv_en = 1'b1;
                n.remaining = wd[`SPP_JOB_LEN];
                n.vel = (wd[`SPP_JOB_VEL] < s.cfg_start) ? s.cfg_start :
                        wd[`SPP_JOB_VEL];
                n.ref_job = wd[`SPP_JOB_REF];
                n.referenced = s.referenced & ~wd[`SPP_JOB_REF];
                n.aborted = 1'b0;
                n.stopping = 1'b0;
                n.setup = DIR_SETUP;
                n.st = ST_SETUP;
              end
            end
          endcase
        end
        default:
        begin
        end
      endcase
    end

    // Ramp time base
    if (s.st == ST_ACCEL || s.st == ST_CRUISE || s.st == ST_DECEL)
    begin
      if (s.tick == 12'h000)
      begin
        n.tick = RAMP_TICK - 12'h001;
        ramp = 1'b1;
      end
      else
      begin
        n.tick = s.tick - 12'h001;
      end
    end

    if (s.step_en && sif.step)
    begin
      n.remaining = s.remaining - 16'h0001;
      if (s.st == ST_ACCEL)
        n.acc_steps = s.acc_steps + 16'h0001;
    end

    if (moving && (ext_stop || (s.ref_job && ref_rise)))
      n.stopping = 1'b1;
    if (moving && s.ref_job && ref_rise && s.cfg_refsw)
    begin
      n.referenced = 1'b1;
      ev[`SPP_EV_REF] = 1'b1;
    end

    up = {1'b0, s.rate} + {1'b0, s.cfg_accel};
    down = {1'b0, s.rate} - {1'b0, s.cfg_accel};

    case (s.st)
      ST_IDLE:
      begin
        n.step_en = 1'b0;
      end
      ST_SETUP:
      begin
        // Direction has settled before stepping starts
        if (s.setup != 8'h00)
          n.setup = s.setup - 8'h01;
        else if (s.remaining == 16'h0000 || s.stopping)
          finish = 1'b1;
        else
        begin
          n.rate = s.cfg_start;
          n.acc_steps = 16'h0000;
          n.tick = RAMP_TICK - 12'h001;
          n.step_en = 1'b1;
          n.st = ST_ACCEL;
        end
      end
      ST_ACCEL:
      begin
        if (ramp)
        begin
          if (up >= {1'b0, s.vel})
          begin
            n.rate = s.vel;
            n.st = ST_CRUISE;
          end
          else
          begin
            n.rate = up[11:0];
          end
        end
        if (n.stopping || n.remaining <= n.acc_steps)
          n.st = ST_DECEL;
      end
      ST_CRUISE:
      begin
        if (n.stopping || n.remaining <= s.acc_steps)
          n.st = ST_DECEL;
      end
      ST_DECEL:
      begin
        if (ramp)
        begin
          if (s.rate <= s.cfg_accel ||
              down[11:0] <= s.cfg_start)
            n.rate = s.cfg_start;
          else
            n.rate = down[11:0];
        end
        if (s.stopping && s.rate == s.cfg_start && n.remaining != 16'h0000)
          halt = 1'b1;
      end
      default:
      begin
        n.st = ST_IDLE;
      end
    endcase

    if (s.step_en && n.remaining == 16'h0000)
      finish = 1'b1;

    // Range limit passed or inhibit: cut pulses with no ramp
    if (moving && (pulse_inhibit_input ||
        (s.dir && limit_fwd) || (!s.dir && limit_bwd)))
      halt = 1'b1;

    if (halt)
    begin
      n.st = ST_IDLE;
      n.step_en = 1'b0;
      n.stopping = 1'b0;
      n.aborted = 1'b1;
      ev[`SPP_EV_ABORT] = 1'b1;
    end
    else if (finish)
    begin
      n.st = ST_IDLE;
      n.step_en = 1'b0;
      n.aborted = s.stopping;
      n.stopping = 1'b0;
      ev[`SPP_EV_DONE] = ~s.stopping;
      ev[`SPP_EV_ABORT] = s.stopping;
    end

    // A new event wins over a clear in the same cycle
    n.irq_stat = (s.irq_stat & ~clr) | ev;
    n.irq = |(n.irq_stat & n.irq_en);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      s <= '0;
      s.waitreq <= 1'b1;
      s.st <= ST_IDLE;
      s.cfg_start <= `SPP_CFG_START_RST;
      s.cfg_accel <= `SPP_CFG_ACCEL_RST;
      s.cfg_refsw <= `SPP_CFG_REFSW_RST;
      s.irq_en <= `SPP_IRQ_EN_RST;
    end
    else
    begin
      s <= n;
    end
  end

  assign sif.rate = s.rate;
  assign sif.en = s.step_en;

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign step_pulse = sif.step;
  assign step_dir = s.dir;
  assign drive_enable = s.drv_en;
  assign configured_indicator = s.configured;
  assign pulsing_indicator = s.step_en;
  assign aborted_indicator = s.aborted;
  assign irq = s.irq;
endmodule // spp_top

/* spp_motor.sv */
`timescale 1ns/1ps
module spp_motor #(
  parameter int LIM = 300
) (
  input wire logic ref_clk, // Clock
  input wire logic step_pulse, // Step in
  input wire logic step_dir, // High forwards
  input wire logic drive_enable, // Power on
  output logic limit_fwd, // Far range switch
  output logic [31:0] pos, // Position
  output logic [31:0] cnt, // Steps taken
  output logic dir_err // Step too soon after a turn
);
  int since = 100;
  logic last_dir = 1'b0;
  initial
  begin
    pos = 32'h0;
    cnt = 32'h0;
    dir_err = 1'b0;
  end
  // Switch closes once the carriage reaches the end of travel
  assign limit_fwd = $signed(pos) >= LIM;
  // Non-blocking updates so the design never races the switch output
  always @(posedge ref_clk)
  begin
    since <= (step_dir !== last_dir) ? 0 : since + 1;
    last_dir <= step_dir;
    if (step_pulse === 1'b1 && drive_enable === 1'b1)
    begin
      cnt <= cnt + 1;
      pos <= step_dir ? pos + 1 : pos - 1;
      if (since < 40 || step_dir !== last_dir)
        dir_err <= 1'b1;
    end
  end
endmodule // spp_motor

/* spp_top_sva.sv */
`timescale 1ns/1ps
module spp_top_sva (
  input wire logic ref_clk, // Clock
  input wire logic rstn, // Reset
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic avs_waitrequest, // Stall
  input wire logic limit_fwd, // Limit
  input wire logic pulse_inhibit_input, // Inhibit
  input wire logic step_pulse, // Step
  input wire logic step_dir, // Direction
  input wire logic drive_enable, // Drive
  input wire logic configured_indicator, // Configured
  input wire logic pulsing_indicator, // Pulsing
  input wire logic aborted_indicator // Aborted
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_WAIT_ONE: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Request not answered after one wait");
  AST_WAIT_PULSE: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("Waitrequest low too long");
  AST_INH_HALT: assert property (
    pulse_inhibit_input && pulsing_indicator
    |=> !pulsing_indicator && aborted_indicator)
    else $error("Inhibit did not halt at once");
  AST_INH_NOSTEP: assert property (
    pulse_inhibit_input ##1 pulse_inhibit_input |=> !step_pulse)
    else $error("Step while inhibited");
  AST_LIM_HALT: assert property (
    limit_fwd && step_dir && pulsing_indicator |=> !pulsing_indicator)
    else $error("Limit did not halt");
  AST_DIR_SETUP: assert property (
    $changed(step_dir) |=> (!step_pulse)[*8])
    else $error("Step too soon after direction change");
  AST_DIR_STABLE: assert property (
    pulsing_indicator && $past(pulsing_indicator) |-> $stable(step_dir))
    else $error("Direction changed during job");
  AST_STEP_DRIVE: assert property (
    step_pulse |-> drive_enable && configured_indicator)
    else $error("Step without drive or configuration");
  AST_CFG_HOLD: assert property (
    configured_indicator |=> configured_indicator)
    else $error("Configured indicator dropped");
  AST_STEP_WIDTH: assert property (
    step_pulse |=> !step_pulse)
    else $error("Step pulse longer than one cycle");
endmodule // spp_top_sva

bind spp_top spp_top_sva spp_top_sva_i (.ref_clk, .rstn, .avs_read,
  .avs_write, .avs_waitrequest, .limit_fwd, .pulse_inhibit_input,
  .step_pulse, .step_dir, .drive_enable, .configured_indicator,
  .pulsing_indicator, .aborted_indicator);

/* testbench.sv */
`timescale 1ns/1ps
`include "spp_regs.svh"
module testbench;
  localparam int LIM = 300;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] avs_address = 5'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic limit_bwd = 1'b0;
  logic ext_stop = 1'b0;
  logic pulse_inhibit_input = 1'b0;
  logic ref_switch = 1'b0;
  logic [31:0] avs_readdata, pos, cnt, rd, c0;
  logic avs_waitrequest, limit_fwd, step_pulse, step_dir, drive_enable;
  logic configured_indicator, pulsing_indicator, aborted_indicator, irq;
  logic dir_err;
  int errors = 0;
  int n_compared = 0;
  always #12.5 ref_clk = ~ref_clk;
  spp_top spp_top_i (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .limit_fwd, .limit_bwd, .ext_stop, .pulse_inhibit_input, .ref_switch,
    .step_pulse, .step_dir, .drive_enable, .configured_indicator,
    .pulsing_indicator, .aborted_indicator, .irq);
  spp_motor #(.LIM(LIM)) spp_motor_i (.ref_clk, .step_pulse, .step_dir,
    .drive_enable, .limit_fwd, .pos, .cnt, .dir_err);

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  function logic [31:0] jw(input logic [15:0] l, input logic [1:0] m);
    return {l, 12'hfff, 2'h0, m};
  endfunction

  task wait_irq(input logic [3:0] exp);
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 20000)
    begin
      @(posedge ref_clk);
      i++;
    end
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, `SPP_ADDR_IRQ_STAT, 32'h0);
    chk(rd, {28'h0, exp});
    bus(1'b1, `SPP_ADDR_IRQ_CLR, 32'hf);
    bus(1'b0, `SPP_ADDR_IRQ_STAT, 32'h0);
    chk({rd[3:0], 3'h0, irq}, 8'h0);
  endtask

  task t_reset;
    bus(1'b0, `SPP_ADDR_CFG, 32'h0);
    chk(rd, 32'h00001010);
    bus(1'b0, `SPP_ADDR_STAT, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 5'h18, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, `SPP_ADDR_IRQ_EN, 32'hf);
    bus(1'b1, `SPP_ADDR_JOB, jw(16'h5, `SPP_MODE_FWD));
    wait_irq(4'h8);
    chk(cnt, 32'h0);
    $display("t_reset done");
  endtask

  task t_fwd_bwd;
    bus(1'b1, `SPP_ADDR_CFG, 32'h00100800);
    bus(1'b0, `SPP_ADDR_CFG, 32'h0);
    chk(rd, 32'h00100800);
    chk({31'h0, configured_indicator}, 32'h1);
    bus(1'b1, `SPP_ADDR_JOB, jw(16'h5, `SPP_MODE_FWD));
    @(posedge ref_clk iff step_pulse === 1'b1);
    c0 = 32'h0;
    do
    begin
      @(posedge ref_clk);
      c0++;
    end
    while (step_pulse !== 1'b1);
    chk(c0, 32'h20);
    wait_irq(4'h1);
    chk(cnt, 32'h5);
    chk({31'h0, step_dir}, 32'h1);
    bus(1'b0, `SPP_ADDR_STAT, 32'h0);
    chk({16'h0, rd[15:0]}, 32'h0);
    bus(1'b1, `SPP_ADDR_JOB, jw(16'h3, `SPP_MODE_BWD));
    wait_irq(4'h1);
    chk(pos, 32'h2);
    chk({31'h0, step_dir}, 32'h0);
    chk({31'h0, dir_err}, 32'h0);
    bus(1'b1, `SPP_ADDR_JOB, jw(16'h0, `SPP_MODE_NEUTRAL));
    repeat (2) @(posedge ref_clk);
    chk({31'h0, drive_enable}, 32'h0);
    $display("t_fwd_bwd done");
  endtask

  task t_limit;
    bus(1'b1, `SPP_ADDR_JOB, jw(16'h1000, `SPP_MODE_FWD));
    wait_irq(4'h2);
    chk({31'h0, pos >= LIM && pos <= LIM + 1}, 32'h1);
    chk({31'h0, aborted_indicator}, 32'h1);
    bus(1'b1, `SPP_ADDR_JOB, jw(16'h5, `SPP_MODE_FWD));
    wait_irq(4'h8);
    limit_bwd <= 1'b1;
    bus(1'b1, `SPP_ADDR_JOB, jw(16'h5, `SPP_MODE_BWD));
    wait_irq(4'h8);
    limit_bwd <= 1'b0;
    $display("t_limit done");
  endtask

  task t_stop;
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, `SPP_ADDR_JOB, jw(16'h1000, `SPP_MODE_BWD));
      // Long enough for the rate to climb above the start rate
      repeat (2000) @(posedge ref_clk);
      if (i == 0)
        bus(1'b1, `SPP_ADDR_JOB, jw(16'h0, `SPP_MODE_STOP));
      else
        ext_stop <= 1'b1;
      c0 = cnt;
      wait_irq(4'h2);
      ext_stop <= 1'b0;
      chk({31'h0, cnt > c0 + 5}, 32'h1);
      chk({31'h0, aborted_indicator}, 32'h1);
    end
    $display("t_stop done");
  endtask

  task t_inhibit;
    bus(1'b1, `SPP_ADDR_JOB, jw(16'h1000, `SPP_MODE_BWD));
    repeat (300) @(posedge ref_clk);
    pulse_inhibit_input <= 1'b1;
    repeat (3) @(posedge ref_clk);
    c0 = cnt;
    repeat (200) @(posedge ref_clk);
    chk(cnt, c0);
    wait_irq(4'h2);
    bus(1'b1, `SPP_ADDR_JOB, jw(16'h5, `SPP_MODE_BWD));
    wait_irq(4'h8);
    pulse_inhibit_input <= 1'b0;
    $display("t_inhibit done");
  endtask

  task t_ref;
    c0 = cnt;
    bus(1'b1, `SPP_ADDR_JOB, jw(16'h0, `SPP_MODE_BWD) | 32'h4);
    wait_irq(4'h4);
    bus(1'b0, `SPP_ADDR_STAT, 32'h0);
    chk({31'h0, rd[`SPP_ST_REFERENCED]}, 32'h1);
    chk(cnt, c0);
    bus(1'b1, `SPP_ADDR_CFG, 32'h01100800);
    bus(1'b1, `SPP_ADDR_JOB, jw(16'h1000, `SPP_MODE_BWD) | 32'h4);
    repeat (2000) @(posedge ref_clk);
    bus(1'b0, `SPP_ADDR_STAT, 32'h0);
    chk({31'h0, rd[`SPP_ST_REFERENCED]}, 32'h0);
    ref_switch <= 1'b1;
    c0 = cnt;
    wait_irq(4'h4);
    wait_irq(4'h2);
    ref_switch <= 1'b0;
    chk({31'h0, cnt > c0 + 5}, 32'h1);
    bus(1'b0, `SPP_ADDR_STAT, 32'h0);
    chk({31'h0, rd[`SPP_ST_REFERENCED]}, 32'h1);
    $display("t_ref done");
  endtask

  task finish_test;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset;
    t_fwd_bwd;
    t_limit;
    t_stop;
    t_inhibit;
    t_ref;
    finish_test;
  end

  initial
  begin
    repeat (90000) @(posedge ref_clk);
    errors++;
    finish_test;
  end
endmodule // testbench
